// >>> rtl/ccm_pkg.sv
/*
  Types of the coherency line maintenance block: operations, snoop kinds, states.
  Assumes nothing of its surroundings.
*/
package ccm_pkg;

  // By-address line maintenance operations
  typedef enum logic [1:0] {
    invalidate_line_to_coherency_point = 2'h0,
    clean_line_to_coherency_point = 2'h1,
    clean_line_to_unification_point = 2'h2,
    clean_invalidate_line_to_coherency_point = 2'h3
  } ccm_op_type;

  // Access kinds from another processor or the coherent master port
  typedef enum logic [1:0] {
    snp_load = 2'h0,
    snp_store = 2'h1,
    snp_data_prefetch_hint = 2'h2
  } ccm_snp_type;

  // Maintenance engine states, one-hot
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_bcast = 7'h02,
    st_check = 7'h04,
    st_wback = 7'h08,
    st_inval = 7'h10,
    st_done = 7'h20,
    st_snpwb = 7'h40
  } ccm_state_type;

endpackage

// >>> rtl/ccm_regs.svh
/*
  Offsets, field positions and reset values of the coherency line maintenance block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef CCM_REGS_SVH
`define CCM_REGS_SVH

// Diagnostic control register, offset from the private peripheral base
`define CCM_DIAG_CTRL_OFF 8'h30
`define CCM_MIG_DIS_BIT 0
`define CCM_MIG_DIS_RESET 1'h0
`define CCM_RDATA_ZERO 32'h0000_0000

`endif

// >>> rtl/ccm_top.sv
/*
  Coherency-side engine for by-address data cache line maintenance, snoops and
  the migratory-transfer disable control.
  Assumes all inputs come from logic on clk; requests are levels held until answered.
*/
`timescale 1ns/1ps
`include "ccm_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module ccm_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Cluster configuration
  input wire logic smp_bcast_en,
  // Maintenance request from local processor
  input wire logic mnt_valid,
  input wire ccm_pkg::ccm_op_type mnt_op,
  input wire logic [31:5] mnt_addr,
  input wire logic line_dirty,
  output logic mnt_done,
  // Broadcast to other processors
  output logic bcast_valid,
  output ccm_pkg::ccm_op_type bcast_op,
  output logic [31:5] bcast_addr,
  input wire logic bcast_ack,
  // Write-back to lower memory and local invalidate
  output logic wb_valid,
  output logic [31:5] wb_addr,
  input wire logic wb_ack,
  output logic line_inv,
  // Snoops from other processors and coherent master port
  input wire logic snp_valid,
  input wire ccm_pkg::ccm_snp_type snp_kind,
  input wire logic [31:5] snp_addr,
  input wire logic snp_dirty,
  output logic snp_grant
);

  ccm_pkg::ccm_state_type state_reg;
  ccm_pkg::ccm_state_type state_next;
  ccm_pkg::ccm_op_type op_reg;
  logic [31:5] addr_reg;
  logic mig_dis_reg;
  logic [31:0] reg_rdata_reg;
  logic mnt_done_reg;
  logic bcast_valid_reg;
  logic wb_valid_reg;
  logic [31:5] wb_addr_reg;
  logic line_inv_reg;
  logic snp_grant_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic diag_hit = reg_addr == `CCM_DIAG_CTRL_OFF;
  wire logic diag_wr = reg_wr && diag_hit;
  wire logic idle = state_reg == ccm_pkg::st_idle;
  wire logic take_mnt = idle && mnt_valid;
  wire logic take_snp = idle && !mnt_valid && snp_valid && !snp_grant_reg;
  wire logic snp_read = snp_kind != ccm_pkg::snp_store;
  wire logic snp_evict = take_snp && mig_dis_reg && snp_read && snp_dirty;
  wire logic op_cleans = op_reg != ccm_pkg::invalidate_line_to_coherency_point;
  wire logic op_invals = op_reg == ccm_pkg::invalidate_line_to_coherency_point
    || op_reg == ccm_pkg::clean_invalidate_line_to_coherency_point;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ccm_pkg::st_idle: begin
        if (take_mnt) begin
          state_next = smp_bcast_en ? ccm_pkg::st_bcast : ccm_pkg::st_check;
        end else if (snp_evict) begin
          state_next = ccm_pkg::st_snpwb;
        end
      end
      ccm_pkg::st_bcast: begin
        if (bcast_ack) begin
          state_next = ccm_pkg::st_check;
        end
      end
      ccm_pkg::st_check: begin
        if (op_cleans && line_dirty) begin
          state_next = ccm_pkg::st_wback;
        end else if (op_invals) begin
          state_next = ccm_pkg::st_inval;
        end else begin
          state_next = ccm_pkg::st_done;
        end
      end
      ccm_pkg::st_wback: begin
        if (wb_ack) begin
          state_next = op_invals ? ccm_pkg::st_inval : ccm_pkg::st_done;
        end
      end
      ccm_pkg::st_inval: state_next = ccm_pkg::st_done;
      ccm_pkg::st_done: state_next = ccm_pkg::st_idle;
      ccm_pkg::st_snpwb: begin
        if (wb_ack) begin
          state_next = ccm_pkg::st_idle;
        end
      end
      default: state_next = ccm_pkg::st_idle;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ccm_pkg::st_idle;
      op_reg <= ccm_pkg::invalidate_line_to_coherency_point;
      addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (take_mnt) begin
        op_reg <= mnt_op;
        addr_reg <= mnt_addr;
      end
    end
  end

  // Outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mnt_done_reg <= 1'b0;
      bcast_valid_reg <= 1'b0;
      wb_valid_reg <= 1'b0;
      wb_addr_reg <= '0;
      line_inv_reg <= 1'b0;
      snp_grant_reg <= 1'b0;
    end else begin
      mnt_done_reg <= state_next == ccm_pkg::st_done;
      bcast_valid_reg <= state_next == ccm_pkg::st_bcast;
      wb_valid_reg <= state_next == ccm_pkg::st_wback
        || state_next == ccm_pkg::st_snpwb;
      if (state_reg == ccm_pkg::st_check) begin
        wb_addr_reg <= addr_reg;
      end else if (snp_evict) begin
        wb_addr_reg <= snp_addr;
      end
      line_inv_reg <= state_next == ccm_pkg::st_inval;
      snp_grant_reg <= (take_snp && !snp_evict)
        || (state_reg == ccm_pkg::st_snpwb && wb_ack);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Diagnostic control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mig_dis_reg <= `CCM_MIG_DIS_RESET;
      reg_rdata_reg <= `CCM_RDATA_ZERO;
    end else begin
      if (diag_wr) begin
        mig_dis_reg <= reg_wdata[`CCM_MIG_DIS_BIT];
      end
      if (reg_rd) begin
        reg_rdata_reg <= `CCM_RDATA_ZERO;
      end
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign mnt_done = mnt_done_reg;
  assign bcast_valid = bcast_valid_reg;
  assign bcast_op = op_reg;
  assign bcast_addr = addr_reg;
  assign wb_valid = wb_valid_reg;
  assign wb_addr = wb_addr_reg;
  assign line_inv = line_inv_reg;
  assign snp_grant = snp_grant_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_WB_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    wb_valid && !wb_ack |=> wb_valid)
    else $error("write-back dropped before acknowledge");

  AST_NO_DONE_BEFORE_WB: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == ccm_pkg::st_wback && !wb_ack |=> !mnt_done)
    else $error("completion before write-back acknowledge");

  AST_BCAST_ON: assert property (@(posedge clk) disable iff (!rst_n)
    take_mnt && smp_bcast_en |=> bcast_valid && bcast_addr == $past(mnt_addr))
    else $error("maintenance not broadcast");

  AST_BCAST_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    take_mnt && !smp_bcast_en |=> !bcast_valid)
    else $error("broadcast while disabled");

  AST_INV_THEN_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    line_inv |=> mnt_done ##1 !mnt_done)
    else $error("invalidate not followed by completion");

  AST_SNP_WAITS: assert property (@(posedge clk) disable iff (!rst_n)
    snp_grant |-> $past(state_reg == ccm_pkg::st_idle || state_reg == ccm_pkg::st_snpwb))
    else $error("snoop granted during maintenance");

  AST_MIG_EVICT: assert property (@(posedge clk) disable iff (!rst_n)
    snp_evict |=> wb_valid && !snp_grant && wb_addr == $past(snp_addr))
    else $error("dirty line not evicted on read");

  AST_MIG_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
    take_snp && !mig_dis_reg && !snp_grant |=> snp_grant && !wb_valid)
    else $error("snoop not served directly");

  AST_MIG_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    diag_wr |=> mig_dis_reg == $past(reg_wdata[`CCM_MIG_DIS_BIT]))
    else $error("diagnostic bit not written");

  AST_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd |=> reg_rdata == `CCM_RDATA_ZERO)
    else $error("diagnostic read not zero");

  AST_GRANT_CLEAN: assert property (@(posedge clk) disable iff (!rst_n)
    snp_grant |-> !wb_valid)
    else $error("snoop granted with eviction pending");

endmodule // ccm_top

// >>> tb/ccm_partner.sv
/*
  Partner model: other processors and lower memory acknowledging broadcasts and write-backs.
  Assumes requests are levels held until the cycle after their acknowledge.
*/
`timescale 1ns/1ps
module ccm_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests and answer delay
  input wire logic bcast_valid,
  input wire logic wb_valid,
  input wire logic [3:0] dly,
  // Acknowledges
  output logic bcast_ack,
  output logic wb_ack
);
  logic [3:0] bc;
  logic [3:0] wc;

  // One-cycle acknowledge after dly waiting cycles; quiet while reset is low
  always @(negedge clk) begin
    if (!rst_n) begin
      bcast_ack <= 1'b0;
      bc <= 4'h0;
      wb_ack <= 1'b0;
      wc <= 4'h0;
    end else begin
      bcast_ack <= bcast_valid && !bcast_ack && bc == dly;
      bc <= (bcast_valid && !bcast_ack && bc != dly) ? bc + 4'h1 : 4'h0;
      wb_ack <= wb_valid && !wb_ack && wc == dly;
      wc <= (wb_valid && !wb_ack && wc != dly) ? wc + 4'h1 : 4'h0;
    end
  end
endmodule // ccm_partner

// >>> tb/ccm_top_tb.sv
/*
  Self-checking bench of the line maintenance engine with its partner model.
  Assumes every request is answered within 200 cycles.
*/
`timescale 1ns/1ps
module ccm_top_tb;
  logic clk, rst_n, reg_wr, reg_rd, smp_bcast_en, mnt_valid, line_dirty, mnt_done;
  logic bcast_valid, bcast_ack, wb_valid, wb_ack, line_inv, snp_valid, snp_dirty, snp_grant;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:5] mnt_addr, bcast_addr, wb_addr, snp_addr;
  logic [3:0] dly;
  logic mig_exp;
  ccm_pkg::ccm_op_type mnt_op, bcast_op;
  ccm_pkg::ccm_snp_type snp_kind;
  int bad_count, checks_done;

  ccm_top i_dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .smp_bcast_en, .mnt_valid, .mnt_op, .mnt_addr, .line_dirty, .mnt_done, .bcast_valid,
    .bcast_op, .bcast_addr, .bcast_ack, .wb_valid, .wb_addr, .wb_ack, .line_inv,
    .snp_valid, .snp_kind, .snp_addr, .snp_dirty, .snp_grant);
  ccm_partner i_partner (.clk, .rst_n, .bcast_valid, .wb_valid, .dly, .bcast_ack, .wb_ack);

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task rreg(input logic [7:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, 32'h0000_0000);
  endtask

  task maint(input ccm_pkg::ccm_op_type op, input logic d, input logic [31:5] a);
    logic b, w, v, ok;
    {b, w, v, ok} = 4'h0;
    @(negedge clk);
    mnt_valid = 1'b1;
    mnt_op = op;
    mnt_addr = a;
    line_dirty = d;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge clk);
      #1;
      b |= bcast_valid && bcast_op === op && bcast_addr === a;
      w |= wb_valid && wb_addr === a;
      v |= line_inv;
      ok = mnt_done;
    end
    if (!ok) begin
      bad_count++;
      test_done;
    end
    @(negedge clk);
    mnt_valid = 1'b0;
    chk(32'(b), 32'(smp_bcast_en));
    chk(32'(w), 32'(d && op != 2'h0));
    chk(32'(v), 32'(op == 2'h0 || op == 2'h3));
  endtask

  task snoop(input ccm_pkg::ccm_snp_type k, input logic d, input logic [31:5] a);
    logic w, ok;
    {w, ok} = 2'h0;
    @(negedge clk);
    snp_valid = 1'b1;
    snp_kind = k;
    snp_addr = a;
    snp_dirty = d;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge clk);
      #1;
      w |= wb_valid && !mnt_valid && wb_addr === a;
      ok = snp_grant;
    end
    if (!ok) begin
      bad_count++;
      test_done;
    end
    @(negedge clk);
    snp_valid = 1'b0;
    chk(32'(w), 32'(mig_exp && d && k != 2'h1));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, smp_bcast_en, mnt_valid, line_dirty, snp_valid, snp_dirty} = 8'h00;
    {reg_addr, reg_wdata, mnt_addr, snp_addr, dly, mig_exp} = 99'h0;
    mnt_op = ccm_pkg::clean_line_to_coherency_point;
    snp_kind = ccm_pkg::snp_load;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(negedge clk);
    chk(32'({mnt_done, bcast_valid, wb_valid, line_inv, snp_grant}), 32'h0);
    rst_n = 1'b1;
    smp_bcast_en = 1'b1;
    for (int i = 0; i < 8; i++) maint(ccm_pkg::ccm_op_type'(i[1:0]), i[2], 27'(i + 'ha00));
    smp_bcast_en = 1'b0;
    dly = 4'h6;
    for (int i = 0; i < 4; i++) maint(ccm_pkg::ccm_op_type'(i[1:0]), 1'b1, 27'(i));
    for (int i = 0; i < 3; i++) snoop(ccm_pkg::ccm_snp_type'(i[1:0]), 1'b1, 27'h77);
    wreg(8'h34, 32'h0000_0001);
    snoop(ccm_pkg::snp_load, 1'b1, 27'h78);
    wreg(8'h30, 32'h0000_0001);
    mig_exp = 1'b1;
    rreg(8'h30);
    rreg(8'h34);
    for (int i = 0; i < 3; i++) snoop(ccm_pkg::ccm_snp_type'(i[1:0]), 1'b1, 27'h79);
    snoop(ccm_pkg::snp_data_prefetch_hint, 1'b0, 27'h7a);
    smp_bcast_en = 1'b1;
    dly = 4'h3;
    fork
      maint(ccm_pkg::clean_invalidate_line_to_coherency_point, 1'b1, 27'h5);
      snoop(ccm_pkg::snp_load, 1'b1, 27'h5);
    join
    fork
      maint(ccm_pkg::clean_line_to_unification_point, 1'b1, 27'h6);
      snoop(ccm_pkg::snp_store, 1'b1, 27'h6);
    join
    test_done;
  end
endmodule // ccm_top_tb
